/* verilog/ldc_pkg.sv */
// Constants and carrier types for the LCD command decoder.
// Assumes a single 100 MHz clock domain and an 8-bit host byte stream.
package ldc_pkg;
  // Clock period in ns
  localparam int LDC_CLK_NS = 10;
  // RAM geometry
  localparam int LDC_PAGES = 8;
  localparam int LDC_COLS = 132;
  localparam logic [7:0] LDC_COL_LAST = 8'h83;
  localparam logic [7:0] LDC_COL_FIRST = 8'h00;
  // Command patterns, don't-care bits marked with ?
  localparam logic [7:0] LDC_OP_DISP = 8'b1010_111?;
  localparam logic [7:0] LDC_OP_START = 8'b01??_????;
  localparam logic [7:0] LDC_OP_PAGE = 8'b1011_????;
  localparam logic [7:0] LDC_OP_COL_HI = 8'b0001_????;
  localparam logic [7:0] LDC_OP_COL_LO = 8'b0000_????;
  localparam logic [7:0] LDC_OP_SEG = 8'b1010_000?;
  localparam logic [7:0] LDC_OP_INV = 8'b1010_011?;
  localparam logic [7:0] LDC_OP_ALLON = 8'b1010_010?;
  localparam logic [7:0] LDC_OP_RMW = 8'hE0;
  localparam logic [7:0] LDC_OP_END = 8'hEE;
  localparam logic [7:0] LDC_OP_RESET = 8'hE2;
  localparam logic [7:0] LDC_OP_COMDIR = 8'b1100_????;
  localparam logic [7:0] LDC_OP_POWER = 8'b0010_1???;
  localparam logic [7:0] LDC_OP_VRANGE = 8'b0010_0???;
  // Status byte bit positions
  localparam int LDC_ST_BUSY = 7;
  localparam int LDC_ST_SEG = 6;
  localparam int LDC_ST_OFF = 5;
  localparam int LDC_ST_RST = 4;
  // Reset values
  localparam logic [5:0] LDC_START_RST = 6'h00;
  localparam logic [2:0] LDC_PAGE_RST = 3'h0;
  localparam logic [2:0] LDC_VRANGE_RST = 3'h0;
  // One buffered host write
  typedef struct packed {
    logic is_data;
    logic [7:0] byte_val;
  } ldc_entry_type;
  // Settings seen by the display timing and power logic
  typedef struct packed {
    logic display_on;
    logic power_save;
    logic [5:0] start_line;
    logic seg_reverse;
    logic inverse;
    logic all_on;
    logic com_reverse;
    logic charge_pump_enable;
    logic pump_regulator_enable;
    logic follower_enable;
    logic [2:0] vrange;
  } ldc_disp_type;
  localparam ldc_disp_type LDC_DISP_RST = '{default: 1'b0};
endpackage

/* verilog/ldc_decoder.sv */
// Command decoder and display RAM access of a dot-matrix LCD driver.
// Host strobes arrive from pins and are synchronised; scan reads come from
// display timing logic on the same clock and take priority over the RAM.
`timescale 1ns/1ps
module ldc_decoder import ldc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic cmd_data_select,
  input wire logic serial_mode,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic scan_rd,
  input wire logic [2:0] scan_page,
  input wire logic [7:0] scan_col,
  output logic [7:0] scan_data,
  output ldc_disp_type disp
);
  // Two-stage synchronisers: strobes, select and data
  logic [11:0] sync1;
  logic [11:0] sync2;
  // Previous synchronised strobes for edge detection
  logic wr_prev;
  logic rd_prev;
  // Display RAM
  logic [7:0] ram [LDC_PAGES][LDC_COLS];
  // Two-entry buffer
  ldc_entry_type buf_mem [2];
  logic buf_wp;
  logic buf_rp;
  logic [1:0] buf_cnt;
  logic next_buf_wp;
  logic next_buf_rp;
  logic [1:0] next_buf_cnt;
  // Address and mode state
  logic [7:0] col;
  logic [2:0] page;
  logic rmw;
  logic [7:0] rmw_col;
  logic [7:0] rd_latch;
  logic reset_flag;
  ldc_disp_type next_disp;
  logic [7:0] next_col;
  logic [2:0] next_page;
  logic next_rmw;
  logic [7:0] next_rmw_col;
  logic [7:0] next_rd_latch;
  logic [7:0] next_data_out;
  logic next_data_oe;
  // Decoded strobe events
  logic s_cs;
  logic s_a0;
  logic [7:0] s_data;
  logic wr_done;
  logic rd_start;
  logic in_valid;
  logic in_ready;
  logic out_valid;
  logic out_ready;
  logic ram_we;
  ldc_entry_type head;

  assign s_cs = ~sync2[11];
  assign s_a0 = sync2[8];
  assign s_data = sync2[7:0];
  // Completed write is the rising edge of the write strobe
  assign wr_done = s_cs & sync2[10] & ~wr_prev;
  assign rd_start = s_cs & ~sync2[9] & rd_prev;
  assign in_valid = wr_done;
  assign in_ready = (buf_cnt != 2'd2);
  assign out_valid = (buf_cnt != 2'd0);
  // A scan read or a host read holds the buffer drain
  assign out_ready = ~scan_rd & ~rd_start;
  assign head = buf_mem[buf_rp];

  // Synchroniser registers; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 12'hE00;
      sync2 <= 12'hE00;
      wr_prev <= 1'b1;
      rd_prev <= 1'b1;
    end else begin
      sync1 <= {cs_n, wr_n, rd_n, cmd_data_select, data_in};
      sync2 <= sync1;
      wr_prev <= sync2[10];
      rd_prev <= sync2[9];
    end
  end

  // Buffer pointer next values
  always_comb begin
    next_buf_wp = buf_wp;
    next_buf_rp = buf_rp;
    next_buf_cnt = buf_cnt;
    // Writes while full are refused
    if (in_valid && in_ready) begin
      next_buf_wp = ~buf_wp;
    end
    if (out_valid && out_ready) begin
      next_buf_rp = ~buf_rp;
    end
    next_buf_cnt = buf_cnt + {1'b0, in_valid & in_ready} - {1'b0, out_valid & out_ready};
  end

  // Buffer pointer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= 2'd0;
    end else begin
      buf_wp <= next_buf_wp;
      buf_rp <= next_buf_rp;
      buf_cnt <= next_buf_cnt;
    end
  end

  // Buffer storage, no reset needed
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      buf_mem[buf_wp] <= '{is_data: s_a0, byte_val: s_data};
    end
  end

  // Executor: one command or data byte per cycle
  always_comb begin
    next_disp = disp;
    next_col = col;
    next_page = page;
    next_rmw = rmw;
    next_rmw_col = rmw_col;
    next_rd_latch = rd_latch;
    next_data_out = data_out;
    next_data_oe = s_cs & ~sync2[9];
    ram_we = 1'b0;
    if (rd_start) begin
      if (!s_a0) begin
        // Status byte
        next_data_out = 8'h00;
        next_data_out[LDC_ST_BUSY] = ~in_ready;
        next_data_out[LDC_ST_SEG] = ~disp.seg_reverse;
        next_data_out[LDC_ST_OFF] = ~disp.display_on;
        next_data_out[LDC_ST_RST] = reset_flag;
      end else if (!serial_mode) begin
        // Latch gives previous word, so first read is dummy
        next_data_out = rd_latch;
        next_rd_latch = ram[page][col];
        // No advance on reads in read-modify-write
        if (!rmw) begin
          if (col == LDC_COL_LAST) begin
            next_col = LDC_COL_FIRST;
            next_page = page + 3'd1;
          end else begin
            next_col = col + 8'd1;
          end
        end
      end
    end else if (out_valid && out_ready) begin
      if (head.is_data) begin
        // Store then advance
        ram_we = 1'b1;
        if (col == LDC_COL_LAST) begin
          next_col = LDC_COL_FIRST;
          next_page = page + 3'd1;
        end else begin
          next_col = col + 8'd1;
        end
      end else begin
        priority casez (head.byte_val)
          LDC_OP_RMW: begin
            next_rmw = 1'b1;
            next_rmw_col = col;
          end
          LDC_OP_END: begin
            // Restore column
            if (rmw) begin
              next_col = rmw_col;
            end
            next_rmw = 1'b0;
          end
          LDC_OP_RESET: begin
            // Soft reset keeps RAM, on/off, inverse, all-on, segment direction and power enables
            next_disp.start_line = LDC_START_RST;
            next_disp.com_reverse = 1'b0;
            next_disp.vrange = LDC_VRANGE_RST;
            next_col = LDC_COL_FIRST;
            next_page = LDC_PAGE_RST;
            next_rmw = 1'b0;
          end
          LDC_OP_DISP: next_disp.display_on = head.byte_val[0];
          LDC_OP_START: next_disp.start_line = head.byte_val[5:0];
          LDC_OP_PAGE: next_page = head.byte_val[2:0];
          LDC_OP_COL_HI: next_col = {head.byte_val[3:0], col[3:0]};
          LDC_OP_COL_LO: next_col = {col[7:4], head.byte_val[3:0]};
          LDC_OP_SEG: next_disp.seg_reverse = head.byte_val[0];
          LDC_OP_INV: next_disp.inverse = head.byte_val[0];
          LDC_OP_ALLON: next_disp.all_on = head.byte_val[0];
          LDC_OP_COMDIR: next_disp.com_reverse = head.byte_val[3];
          LDC_OP_POWER: begin
            // Power circuit enables
            next_disp.charge_pump_enable = head.byte_val[2];
            next_disp.pump_regulator_enable = head.byte_val[1];
            next_disp.follower_enable = head.byte_val[0];
          end
          LDC_OP_VRANGE: next_disp.vrange = head.byte_val[2:0];
          default: begin
            // Unsupported codes are ignored
            next_rmw = rmw;
          end
        endcase
      end
    end
    // Power save while all-on with display off
    next_disp.power_save = next_disp.all_on & ~next_disp.display_on;
  end

  // Executor registers; reset pin clears everything except reset_flag, which it sets
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      disp <= LDC_DISP_RST;
      col <= LDC_COL_FIRST;
      page <= LDC_PAGE_RST;
      rmw <= 1'b0;
      rmw_col <= LDC_COL_FIRST;
      rd_latch <= 8'h00;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      reset_flag <= 1'b1;
    end else begin
      disp <= next_disp;
      col <= next_col;
      page <= next_page;
      rmw <= next_rmw;
      rmw_col <= next_rmw_col;
      rd_latch <= next_rd_latch;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
      reset_flag <= 1'b0;
    end
  end

  // RAM write and scan read ports
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram[page][col] <= head.byte_val;
    end
    if (scan_rd) begin
      scan_data <= ram[scan_page][scan_col];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Command byte at buffer head
  sequence cmd_taken(logic [7:0] op);
    out_valid && out_ready && !rd_start && !head.is_data && head.byte_val == op;
  endsequence

  disp_onoff_a: assert property ((out_valid && out_ready && !rd_start
    && !head.is_data && head.byte_val[7:1] == 7'h57)
    |=> disp.display_on == $past(head.byte_val[0]))
    else $error("display on/off not applied");
  // All-on taken while the display is off must land in power save
  power_save_a: assert property ((!disp.display_on ##0 cmd_taken(8'hA5))
    |=> disp.power_save) else $error("power save not entered");
  col_wrap_a: assert property ((out_valid && out_ready && !rd_start
    && head.is_data && col == LDC_COL_LAST)
    |=> col == LDC_COL_FIRST && page == $past(page) + 3'd1)
    else $error("column wrap wrong");
  status_a: assert property ((rd_start && !s_a0) |=> data_out[3:0] == 4'h0
    && data_out[LDC_ST_OFF] == !$past(disp.display_on))
    else $error("status byte wrong");
  busy_refuse_a: assert property ((buf_cnt == 2'd2 && !(out_valid && out_ready))
    |=> buf_cnt == 2'd2) else $error("full buffer took a byte");
  rmw_read_a: assert property ((rmw && rd_start && s_a0) |=> col == $past(col))
    else $error("read advanced column in rmw");
  rmw_end_a: assert property ((rmw ##0 cmd_taken(LDC_OP_END))
    |=> col == $past(rmw_col) && !rmw) else $error("end did not restore column");
  soft_reset_a: assert property (cmd_taken(LDC_OP_RESET) |=> col == LDC_COL_FIRST
    && page == LDC_PAGE_RST && !rmw && disp.start_line == LDC_START_RST)
    else $error("soft reset incomplete");
  reset_flag_a: assert property (reset_flag |=> !reset_flag)
    else $error("reset flag stuck");
endmodule

/* testbench/ldc_host_model.sv */
// Host bus model for the LCD command decoder: write and read cycles on its pins.
// Assumes the decoder samples pins on clk and wants strobe phases of 4+ cycles.
`timescale 1ns/1ps
module ldc_host_model import ldc_pkg::*; (
  input wire logic clk,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic cmd_data_select,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  initial begin // Pins idle inactive from time zero
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    cmd_data_select = 1'b0;
    data_in = 8'h00;
  end
  task automatic cycle(input logic wr, input logic a0, input logic [7:0] b,
    output logic [7:0] d);
    @(negedge clk); // Pins held until the strobe has risen and settled
    cs_n = 1'b0;
    cmd_data_select = a0;
    data_in = b;
    wr_n = ~wr; // Write strobe low for a write
    rd_n = wr; // Read strobe low for a read
    repeat (6) @(negedge clk);
    d = (data_oe === 1'b1) ? data_out : 'x; // No enable, no valid byte
    wr_n = 1'b1;
    rd_n = 1'b1;
    repeat (4) @(negedge clk);
    data_in = ~b; // Released bus shows no stale byte
    cs_n = 1'b1;
    repeat (4) @(negedge clk); // Lets a queued command drain
  endtask
endmodule

/* testbench/lcd_driver_command_decoder_tb_top.sv */
// Self-checking bench for the LCD command decoder: host cycles, scan reads, settings.
// Assumes ldc_pkg, ldc_decoder and ldc_host_model are compiled ahead of it.
`timescale 1ns/1ps
module lcd_driver_command_decoder_tb_top import ldc_pkg::*; ();
  logic clk = 1'b0;
  logic cs_n, wr_n, rd_n, cmd_data_select, data_oe;
  logic rst_n = 1'b0, serial_mode = 1'b0, scan_rd = 1'b0; // Inputs known at time zero
  logic [2:0] scan_page = 3'h0;
  logic [7:0] scan_col = 8'h00, scan_data, data_in, data_out, v;
  ldc_disp_type disp, e = LDC_DISP_RST; // Settings seen and expected
  int miscompares = 0, n_checks = 0;
  ldc_decoder u_ldc_decoder (.clk, .rst_n, .cs_n, .wr_n, .rd_n, .cmd_data_select,
    .serial_mode, .data_in, .data_out, .data_oe, .scan_rd, .scan_page, .scan_col,
    .scan_data, .disp);
  ldc_host_model u_ldc_host_model (.clk, .cs_n, .wr_n, .rd_n, .cmd_data_select,
    .data_in, .data_out, .data_oe);
  initial forever #5 clk = ~clk; // Free-running 100 MHz clock
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t byte %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_disp(input ldc_disp_type exp);
    n_checks++;
    if (disp !== exp) begin
      miscompares++;
      $display("FAIL %0t settings %h exp %h", $time, disp, exp);
    end
  endtask
  task automatic give_verdict(); // Counts, verdict and end of run
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] b); // Command byte
    u_ldc_host_model.cycle(1'b1, 1'b0, b, v);
  endtask
  task automatic dat(input logic [7:0] b); // Display data byte
    u_ldc_host_model.cycle(1'b1, 1'b1, b, v);
  endtask
  task automatic rd(input logic a0, input logic chk, input logic [7:0] x); // Read
    u_ldc_host_model.cycle(1'b0, a0, 8'h00, v);
    if (chk) check_byte(v, x);
  endtask
  task automatic scan(input logic [2:0] p, input logic [7:0] c, input logic [7:0] x);
    scan_rd = 1'b1; // Answer is due on the next cycle
    scan_page = p;
    scan_col = c;
    @(negedge clk);
    scan_rd = 1'b0;
    @(negedge clk);
    check_byte(scan_data, x);
  endtask
  initial begin // Cut-off far beyond the some 860 cycles needed
    #200000;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    scan_rd = 1'b1; // Stalls the drain so the queue fills
    cmd(8'hAF);
    cmd(8'h41);
    cmd(8'h45);
    rd(1'b0, 1'b1, 8'hE0);
    check_disp(e);
    scan_rd = 1'b0;
    repeat (8) @(negedge clk);
    e.display_on = 1'b1;
    e.start_line = 6'h01;
    check_disp(e);
    cmd(8'h7F);
    cmd(8'hA1);
    cmd(8'hA7);
    cmd(8'hC8);
    e.start_line = 6'h3F;
    e.seg_reverse = 1'b1;
    e.inverse = 1'b1;
    e.com_reverse = 1'b1;
    check_disp(e);
    rd(1'b0, 1'b1, 8'h00);
    for (int i = 0; i < 8; i++) begin
      cmd(8'h28 | 8'(i));
      cmd(8'h20 | 8'(i));
      {e.charge_pump_enable, e.pump_regulator_enable, e.follower_enable} = 3'(i);
      e.vrange = 3'(i);
      check_disp(e);
    end
    cmd(8'hAE);
    cmd(8'hA5);
    e.display_on = 1'b0;
    e.all_on = 1'b1;
    e.power_save = 1'b1;
    check_disp(e);
    cmd(8'hA4);
    e.all_on = 1'b0;
    e.power_save = 1'b0;
    check_disp(e);
    cmd(8'hB2);
    cmd(8'h02);
    cmd(8'h13);
    dat(8'hA5);
    dat(8'h5A);
    cmd(8'h13);
    cmd(8'h02);
    rd(1'b1, 1'b0, 8'h00);
    rd(1'b1, 1'b1, 8'hA5);
    rd(1'b1, 1'b1, 8'h5A);
    cmd(8'hB3);
    cmd(8'h18);
    cmd(8'h03);
    dat(8'h11);
    dat(8'h22);
    scan(3'h4, 8'h00, 8'h22);
    cmd(8'hB2);
    cmd(8'h13);
    cmd(8'h02);
    cmd(8'hE0);
    rd(1'b1, 1'b0, 8'h00);
    rd(1'b1, 1'b1, 8'hA5);
    dat(8'hC3);
    cmd(8'hEE);
    dat(8'h77);
    cmd(8'hE2);
    e.start_line = 6'h00;
    e.com_reverse = 1'b0;
    e.vrange = 3'h0;
    check_disp(e);
    scan(3'h2, 8'h32, 8'h77);
    serial_mode = 1'b1; // Serial host: data reads leave output and column alone
    rd(1'b1, 1'b1, 8'hA5);
    rd(1'b1, 1'b1, 8'hA5);
    serial_mode = 1'b0;
    dat(8'h3C);
    scan(3'h0, 8'h00, 8'h3C);
    rst_n = 1'b0;
    @(negedge clk);
    check_disp(LDC_DISP_RST);
    give_verdict();
  end
endmodule
